// ### rtl/clps_top.sv
// camera link power supervisor: APB registers, interrupts, one sequencer per connector
// assumes an APB master on sys_clk_i and asynchronous connector pins
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// (RQ1) status bit 0 reads one while camera supply power is on; read-only
// (RQ2) status bit 2 reads one while the presence sense is enabled
// (RQ3) bit 6 shows live over-current; bit 7 latches it sticky
// (RQ4) bit 9 latches sticky when the link pixel clock disappears
// (RQ5) bit 10 reads one while a link clock is being detected
// (RQ6) bits 12..11 show the power sequencer state
// (RQ7) bit 13 set restarts the sequence after over-current instead of halting
// (RQ8) bit 14 set skips the presence check and applies power directly
// (RQ9) bit 15 enables delivery; the sequencer runs only while it is set
// (RQ10) four 11-bit timing fields at bits 10..0 and 26..16 of two registers
// (RQ11) each connector has its own identical supervisor and register set
module clps_top
  import clps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire clps_pins_t [NCONN-1:0] pins_i,
  output logic [NCONN-1:0] power_en_o,
  output logic [NCONN-1:0] sense_en_o
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] reg_index(input int conn, input int kind);
    reg_index = ADDR_W'(CONN0_STAT_IDX + conn * CONN_STRIDE + kind);
  endfunction : reg_index

  function automatic logic [31:0] pack_status(input clps_status_t s, input clps_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[POS_POWER] = s.power_applied_flag;
    w[POS_SENSE] = s.sense_enabled_flag;
    w[POS_HWDIS] = s.hardware_disable_flag;
    w[POS_OPEN] = s.open_circuit_flag;
    w[POS_OC_LIVE] = s.overcurrent_live_flag;
    w[POS_OC_STICKY] = s.overcurrent_sticky_flag;
    w[POS_LOST] = s.link_clock_lost_sticky;
    w[POS_CLK] = s.link_clock_present;
    w[POS_STATE +: ST_W] = s.power_fsm_state;
    w[POS_RETRY] = c.overcurrent_auto_retry;
    w[POS_SKIP] = c.sense_skip_test;
    w[POS_ENABLE] = c.power_delivery_enable;
    pack_status = w;
  endfunction : pack_status

  function automatic logic [31:0] pack_pair(input logic [TMR_W-1:0] lo,
                                            input logic [TMR_W-1:0] hi);
    logic [31:0] w;
    w = '0;
    w[POS_LO_FIELD +: TMR_W] = lo;
    w[POS_HI_FIELD +: TMR_W] = hi;
    pack_pair = w;
  endfunction : pack_pair

  // ****************************************************************
  // tick divider
  // ****************************************************************
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  always_comb
  begin
    tick_d = (tick_cnt_q == TICK_W'(TICK_CYC - 1));
    tick_cnt_d = tick_d ? '0 : tick_cnt_q + TICK_W'(1);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // ****************************************************************
  // connector supervisors
  // ****************************************************************
  clps_cfg_t [NCONN-1:0] cfg_q, cfg_d;
  clps_status_t [NCONN-1:0] status;
  logic [NCONN-1:0] sticky_clr;
  logic [NCONN-1:0] oc_event;
  logic [NCONN-1:0] lost_event;

  for (genvar g = 0; g < NCONN; g++)
  begin : g_conn
    clps_supervisor u_sup ( // (RQ11)
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .tick_i(tick_q),
      .sticky_clr_i(sticky_clr[g]),
      .cfg_i(cfg_q[g]),
      .pins_i(pins_i[g]),
      .status_o(status[g]),
      .power_en_o(power_en_o[g]),
      .sense_en_o(sense_en_o[g]),
      .oc_event_o(oc_event[g]),
      .lost_event_o(lost_event[g])
    );
  end

  // ****************************************************************
  // APB slave and registers
  // ****************************************************************
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic [ADDR_W-1:0] idx;
  logic hit;
  logic wr_en;
  logic [IRQ_W-1:0] irq_set;

  always_comb
  begin
    idx = paddr_i[ADDR_W+1:2];
    wr_en = psel_i && penable_i && pready_q && pwrite_i;
    pready_d = psel_i && penable_i && !pready_q;
    cfg_d = cfg_q;
    sticky_clr = '0;
    irq_mask_d = irq_mask_q;
    prdata_d = prdata_q;
    hit = 1'b0;
    for (int c = 0; c < NCONN; c++)
    begin
      irq_set[2 * c + IRQ_OC] = oc_event[c];
      irq_set[2 * c + IRQ_LOST] = lost_event[c];
    end
    irq_stat_d = irq_stat_q | irq_set;
    if (idx == ADDR_W'(IRQ_STAT_IDX))
    begin
      hit = 1'b1;
      prdata_d = 32'(irq_stat_q);
      if (wr_en)
      begin
        irq_stat_d = (irq_stat_q & ~pwdata_i[IRQ_W-1:0]) | irq_set;
      end
    end
    if (idx == ADDR_W'(IRQ_MASK_IDX))
    begin
      hit = 1'b1;
      prdata_d = 32'(irq_mask_q);
      if (wr_en)
      begin
        irq_mask_d = pwdata_i[IRQ_W-1:0];
      end
    end
    for (int c = 0; c < NCONN; c++)
    begin
      if (idx == reg_index(c, KIND_STAT))
      begin
        hit = 1'b1;
        prdata_d = pack_status(status[c], cfg_q[c]);
        if (wr_en)
        begin
          sticky_clr[c] = 1'b1;
          cfg_d[c].overcurrent_auto_retry = pwdata_i[POS_RETRY]; // (RQ7)
          cfg_d[c].sense_skip_test = pwdata_i[POS_SKIP]; // (RQ8)
          cfg_d[c].power_delivery_enable = pwdata_i[POS_ENABLE]; // (RQ9)
        end
      end
      if (idx == reg_index(c, KIND_TMR_A))
      begin
        hit = 1'b1;
        prdata_d = pack_pair(cfg_q[c].off_interval, cfg_q[c].settle_interval);
        if (wr_en)
        begin
          cfg_d[c].off_interval = pwdata_i[POS_LO_FIELD +: TMR_W]; // (RQ10)
          cfg_d[c].settle_interval = pwdata_i[POS_HI_FIELD +: TMR_W];
        end
      end
      if (idx == reg_index(c, KIND_TMR_B))
      begin
        hit = 1'b1;
        prdata_d = pack_pair(cfg_q[c].on_interval, cfg_q[c].unplug_interval);
        if (wr_en)
        begin
          cfg_d[c].on_interval = pwdata_i[POS_LO_FIELD +: TMR_W]; // (RQ10)
          cfg_d[c].unplug_interval = pwdata_i[POS_HI_FIELD +: TMR_W];
        end
      end
    end
    if (paddr_i[31:ADDR_W+2] != '0 || paddr_i[1:0] != 2'h0)
    begin
      hit = 1'b0;
    end
    if (!hit)
    begin
      prdata_d = '0;
    end
    if (!pready_d || pwrite_i)
    begin
      prdata_d = '0;
    end
    pslverr_d = pready_d && !hit;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_q <= {NCONN{CFG_RST}};
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o = irq_q;

endmodule : clps_top

// ### rtl/clps_pkg.sv
// constants, field layout and types of the camera link power supervisor
// assumes one 125 MHz system clock and a 32-bit APB register bus
package clps_pkg;

  localparam int NCONN = 3;
  localparam int TMR_W = 11;
  localparam int ST_W = 2;

  // ****************************************************************
  // register map: word index, byte address is four times the index
  // ****************************************************************
  localparam int CONN0_STAT_IDX = 104;
  localparam int CONN_STRIDE = 32;
  localparam int KIND_STAT = 0;
  localparam int KIND_TMR_A = 1;
  localparam int KIND_TMR_B = 2;
  localparam int KIND_NUM = 3;
  localparam int IRQ_STAT_IDX = 240;
  localparam int IRQ_MASK_IDX = 241;
  localparam int ADDR_W = 12;

  // ****************************************************************
  // status/control field positions
  // ****************************************************************
  localparam int POS_POWER = 0;
  localparam int POS_SENSE = 2;
  localparam int POS_HWDIS = 3;
  localparam int POS_OPEN = 5;
  localparam int POS_OC_LIVE = 6;
  localparam int POS_OC_STICKY = 7;
  localparam int POS_LOST = 9;
  localparam int POS_CLK = 10;
  localparam int POS_STATE = 11;
  localparam int POS_RETRY = 13;
  localparam int POS_SKIP = 14;
  localparam int POS_ENABLE = 15;
  localparam int POS_LO_FIELD = 0;
  localparam int POS_HI_FIELD = 16;

  // interrupt bits: two events per connector
  localparam int IRQ_W = 2 * NCONN;
  localparam int IRQ_OC = 0;
  localparam int IRQ_LOST = 1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_CLK_MHZ = 125;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int TICK_W = 8;
  localparam int CLK_LOSS_NS = 1000;
  localparam int CLK_LOSS_CYC = (CLK_LOSS_NS * SYS_CLK_MHZ) / 1000;
  localparam int LOSS_W = 8;

  // timer reset values, in ticks
  localparam logic [TMR_W-1:0] OFF_RST = 11'h064;
  localparam logic [TMR_W-1:0] SETTLE_RST = 11'h032;
  localparam logic [TMR_W-1:0] ON_RST = 11'h0c8;
  localparam logic [TMR_W-1:0] UNPLUG_RST = 11'h064;

  typedef enum logic [ST_W-1:0] {
    ST_OFF = 2'b00,
    ST_SENSE = 2'b01,
    ST_ON = 2'b10,
    ST_UNPLUG = 2'b11
  } clps_state_t;

  typedef struct packed {
    logic camera_present;
    logic overcurrent;
    logic open_circuit;
    logic hw_disable;
    logic link_clk;
  } clps_pins_t;

  typedef struct packed {
    logic overcurrent_auto_retry;
    logic sense_skip_test;
    logic power_delivery_enable;
    logic [TMR_W-1:0] off_interval;
    logic [TMR_W-1:0] settle_interval;
    logic [TMR_W-1:0] on_interval;
    logic [TMR_W-1:0] unplug_interval;
  } clps_cfg_t;

  typedef struct packed {
    logic power_applied_flag;
    logic sense_enabled_flag;
    logic hardware_disable_flag;
    logic open_circuit_flag;
    logic overcurrent_live_flag;
    logic overcurrent_sticky_flag;
    logic link_clock_lost_sticky;
    logic link_clock_present;
    logic [ST_W-1:0] power_fsm_state;
  } clps_status_t;

  localparam clps_cfg_t CFG_RST = '{
    overcurrent_auto_retry: 1'b0,
    sense_skip_test: 1'b0,
    power_delivery_enable: 1'b0,
    off_interval: OFF_RST,
    settle_interval: SETTLE_RST,
    on_interval: ON_RST,
    unplug_interval: UNPLUG_RST
  };

endpackage : clps_pkg

// ### rtl/clps_supervisor.sv
// one connector: pin synchronisers, link clock watch and power sequencer
// assumes pins are asynchronous and tick_i is a one-cycle 1 us enable
`timescale 1ns/1ns
module clps_supervisor
  import clps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  input wire logic sticky_clr_i,
  input wire clps_cfg_t cfg_i,
  input wire clps_pins_t pins_i,
  output clps_status_t status_o,
  output logic power_en_o,
  output logic sense_en_o,
  output logic oc_event_o,
  output logic lost_event_o
);

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  clps_pins_t meta_q;
  clps_pins_t sync_q;
  logic clk_prev_q;
  logic oc_prev_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
      clk_prev_q <= 1'b0;
      oc_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pins_i;
      sync_q <= meta_q;
      clk_prev_q <= sync_q.link_clk;
      oc_prev_q <= sync_q.overcurrent;
    end
  end

  // ****************************************************************
  // link clock presence
  // ****************************************************************
  logic [LOSS_W-1:0] loss_cnt_q, loss_cnt_d;
  logic present_q, present_d;
  logic lost_q, lost_d;
  logic oc_sticky_q, oc_sticky_d;
  logic oc_ev_q, oc_ev_d;
  logic lost_ev_q, lost_ev_d;

  always_comb
  begin
    loss_cnt_d = loss_cnt_q;
    present_d = present_q;
    if (sync_q.link_clk != clk_prev_q)
    begin
      loss_cnt_d = '0;
      present_d = 1'b1;
    end
    else if (loss_cnt_q == LOSS_W'(CLK_LOSS_CYC - 1))
    begin
      present_d = 1'b0;
    end
    else
    begin
      loss_cnt_d = loss_cnt_q + LOSS_W'(1);
    end
    lost_ev_d = present_q && !present_d;
    oc_ev_d = sync_q.overcurrent && !oc_prev_q;
    lost_d = lost_ev_d || (lost_q && !sticky_clr_i); // (RQ4)
    oc_sticky_d = sync_q.overcurrent || (oc_sticky_q && !sticky_clr_i); // (RQ3)
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      loss_cnt_q <= '0;
      present_q <= 1'b0;
      lost_q <= 1'b0;
      oc_sticky_q <= 1'b0;
      oc_ev_q <= 1'b0;
      lost_ev_q <= 1'b0;
    end
    else
    begin
      loss_cnt_q <= loss_cnt_d;
      present_q <= present_d;
      lost_q <= lost_d;
      oc_sticky_q <= oc_sticky_d;
      oc_ev_q <= oc_ev_d;
      lost_ev_q <= lost_ev_d;
    end
  end

  // ****************************************************************
  // power sequencer
  // ****************************************************************
  clps_state_t state_q, state_d;
  logic [TMR_W-1:0] timer_q, timer_d;
  logic halt_q, halt_d;
  logic power_q, power_d;
  logic sense_q, sense_d;
  logic run;
  logic expired;

  always_comb
  begin
    run = cfg_i.power_delivery_enable && !sync_q.hw_disable && !halt_q; // (RQ9)
    expired = (timer_q == '0);
    state_d = state_q;
    timer_d = (tick_i && !expired) ? timer_q - TMR_W'(1) : timer_q;
    halt_d = halt_q && cfg_i.power_delivery_enable;
    if (!run)
    begin
      state_d = ST_OFF;
      timer_d = cfg_i.off_interval;
    end
    else
    begin
      unique case (state_q)
        ST_OFF:
        begin
          if (expired)
          begin
            if (cfg_i.sense_skip_test)
            begin
              state_d = ST_ON; // (RQ8)
              timer_d = cfg_i.on_interval;
            end
            else
            begin
              state_d = ST_SENSE;
              timer_d = cfg_i.settle_interval; // (RQ10)
            end
          end
        end
        ST_SENSE:
        begin
          if (cfg_i.sense_skip_test)
          begin
            state_d = ST_ON; // (RQ8)
            timer_d = cfg_i.on_interval;
          end
          else if (!sync_q.camera_present)
          begin
            timer_d = cfg_i.settle_interval;
          end
          else if (expired)
          begin
            state_d = ST_ON;
            timer_d = cfg_i.on_interval; // (RQ10)
          end
        end
        ST_ON:
        begin
          if (sync_q.overcurrent)
          begin
            state_d = ST_OFF;
            timer_d = cfg_i.off_interval;
            halt_d = !cfg_i.overcurrent_auto_retry; // (RQ7)
          end
          else if (expired && sync_q.open_circuit && !cfg_i.sense_skip_test)
          begin
            state_d = ST_UNPLUG;
            timer_d = cfg_i.unplug_interval; // (RQ10)
          end
        end
        ST_UNPLUG:
        begin
          if (expired)
          begin
            state_d = ST_OFF;
            timer_d = cfg_i.off_interval;
          end
        end
      endcase
    end
    power_d = (state_d == ST_ON);
    sense_d = (state_d == ST_SENSE);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= ST_OFF;
      timer_q <= OFF_RST;
      halt_q <= 1'b0;
      power_q <= 1'b0;
      sense_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      halt_q <= halt_d;
      power_q <= power_d;
      sense_q <= sense_d;
    end
  end

  always_comb
  begin
    status_o.power_applied_flag = power_q; // (RQ1)
    status_o.sense_enabled_flag = sense_q; // (RQ2)
    status_o.hardware_disable_flag = sync_q.hw_disable;
    status_o.open_circuit_flag = sync_q.open_circuit;
    status_o.overcurrent_live_flag = sync_q.overcurrent; // (RQ3)
    status_o.overcurrent_sticky_flag = oc_sticky_q;
    status_o.link_clock_lost_sticky = lost_q;
    status_o.link_clock_present = present_q; // (RQ5)
    status_o.power_fsm_state = state_q; // (RQ6)
  end

  assign power_en_o = power_q;
  assign sense_en_o = sense_q;
  assign oc_event_o = oc_ev_q;
  assign lost_event_o = lost_ev_q;

endmodule : clps_supervisor

// ### dv/clps_checker.sv
// port assertions of the power supervisor
// assumes binding to clps_top, one clock domain
`timescale 1ns/1ns
module clps_checker
  import clps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic irq_o,
  input wire clps_pins_t [NCONN-1:0] pins_i,
  input wire logic [NCONN-1:0] power_en_o,
  input wire logic [NCONN-1:0] sense_en_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic done;
  assign done = psel_i && penable_i && pready_o;
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence access_s;
    psel_i && penable_i && !pready_o ##1 pready_o;
  endsequence

  apb_wait_a: assert property (setup_s |=> access_s)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  idle_data_a: assert property (!(pready_o && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("read data outside a read");
  stat_rsvd_a: assert property (done && !pwrite_i && paddr_i inside {32'h1a0, 32'h220,
    32'h2a0} |-> (prdata_o & 32'hffff0112) == 32'h0)
    else $error("status reserved bit set");
  tmr_rsvd_a: assert property (done && !pwrite_i && paddr_i inside {32'h1a4, 32'h1a8,
    32'h224, 32'h228, 32'h2a4, 32'h2a8} |-> (prdata_o & 32'hf800f800) == 32'h0)
    else $error("timer reserved bit set");
  irq_mask_a: assert property (done && pwrite_i && paddr_i == 32'h3c4
    && pwdata_i[5:0] == 6'h00 |-> ##2 !irq_o)
    else $error("interrupt with all masked");

  for (genvar c = 0; c < NCONN; c++)
  begin : g_conn
    hw_off_a: assert property (pins_i[c].hw_disable [*8] |-> !power_en_o[c])
      else $error("power on while disabled");
    oc_off_a: assert property (pins_i[c].overcurrent [*8] |-> !power_en_o[c])
      else $error("power on during overcurrent");
    en_off_a: assert property (done && pwrite_i && paddr_i == 32'(416 + 128 * c)
      && !pwdata_i[15] |-> ##4 !power_en_o[c])
      else $error("power stays after disable");
    excl_a: assert property (!(power_en_o[c] && sense_en_o[c]))
      else $error("power and sense together");
  end

endmodule : clps_checker

bind clps_top clps_checker i_clps_checker (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .irq_o(irq_o), .pins_i(pins_i), .power_en_o(power_en_o), .sense_en_o(sense_en_o));

// ### dv/clps_camera_model.sv
// camera side of each connector: feed load, sense and link clock
// assumes power_en_i from the supervisor; link clock unrelated to sys clock
`timescale 1ns/1ns
module clps_camera_model
  import clps_pkg::*;
(
  input wire logic [NCONN-1:0] power_en_i,
  input wire logic [NCONN-1:0] plugged_i,
  input wire logic [NCONN-1:0] fault_i,
  input wire logic [NCONN-1:0] hw_off_i,
  input wire logic [NCONN-1:0] clk_run_i,
  output clps_pins_t [NCONN-1:0] pins_o
);
  logic osc = 1'b0;
  always #7 osc = !osc;
  // clock only from a powered camera; unloaded feed reads open
  always_comb
  begin
    for (int c = 0; c < NCONN; c++)
    begin
      pins_o[c].camera_present = plugged_i[c];
      pins_o[c].overcurrent = fault_i[c];
      pins_o[c].open_circuit = power_en_i[c] && !plugged_i[c];
      pins_o[c].hw_disable = hw_off_i[c];
      pins_o[c].link_clk = power_en_i[c] && plugged_i[c] && clk_run_i[c] && osc;
    end
  end
endmodule : clps_camera_model

// ### dv/clps_top_test.sv
// self-checking bench of the supervisor with a camera model
// assumes the design package and a 125 MHz clock
`timescale 1ns/1ns
module clps_top_test
  import clps_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, irq_o, err;
  clps_pins_t [NCONN-1:0] pins;
  logic [NCONN-1:0] power_en_o, sense_en_o;
  logic [NCONN-1:0] plugged = '1;
  logic [NCONN-1:0] fault = '0;
  logic [NCONN-1:0] hw_off = '0;
  logic [NCONN-1:0] clk_run = '1;
  logic [31:0] seed = 32'h29;
  logic [31:0] rd;
  logic [31:0] bad_a [3] = '{32'h1ac, 32'h3c8, 32'h1a1};
  int bad_count = 0;
  int checked = 0;
  always #4 sys_clk_i = !sys_clk_i;

  clps_top i_clps_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .pins_i(pins), .power_en_o(power_en_o), .sense_en_o(sense_en_o));
  clps_camera_model i_clps_camera_model (.power_en_i(power_en_o), .plugged_i(plugged),
    .fault_i(fault), .hw_off_i(hw_off), .clk_run_i(clk_run), .pins_o(pins));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] addr(input int c, input int k);
    return 32'((CONN0_STAT_IDX + CONN_STRIDE * c + k) * 4);
  endfunction : addr
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20)
      bad_count++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : apb
  // s selects sense, else power
  task automatic wait_en(input logic s, input int c, input logic v, input int lim);
    int n;
    n = 0;
    while ((s ? sense_en_o[c] : power_en_o[c]) !== v && n < lim)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    chk_bit(s ? sense_en_o[c] : power_en_o[c], v);
  endtask : wait_en
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    test_done();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int c = 0; c < NCONN; c++)
    begin
      apb(1'b0, addr(c, KIND_STAT), 32'h0);
      chk_word(rd, 32'h0);
      apb(1'b0, addr(c, KIND_TMR_A), 32'h0);
      chk_word(rd, {5'h0, SETTLE_RST, 5'h0, OFF_RST});
      apb(1'b0, addr(c, KIND_TMR_B), 32'h0);
      chk_word(rd, {5'h0, UNPLUG_RST, 5'h0, ON_RST});
      for (int k = KIND_TMR_A; k <= KIND_TMR_B; k++)
      begin
        seed = xs(seed);
        apb(1'b1, addr(c, k), seed);
        apb(1'b0, addr(c, k), 32'h0);
        chk_word(rd, seed & 32'h07ff07ff);
        apb(1'b1, addr(c, k), (k == KIND_TMR_A) ? 32'h00020001 : 32'h00010002);
      end
      apb(1'b1, addr(c, KIND_STAT), 32'h00007fff);
      apb(1'b0, addr(c, KIND_STAT), 32'h0);
      chk_word(rd, 32'h00006000);
      apb(1'b1, addr(c, KIND_STAT), 32'h0);
    end
    foreach (bad_a[i])
    begin
      apb(1'b0, bad_a[i], 32'h0);
      chk_word(rd, 32'h0);
      chk_bit(err, 1'b1);
    end
    for (int c = 0; c < NCONN; c++)
    begin
      apb(1'b1, addr(c, KIND_STAT), 32'h00008000);
      wait_en(1'b1, c, 1'b1, 1000);
      wait_en(1'b0, c, 1'b1, 1000);
    end
    repeat (20) @(posedge sys_clk_i);
    for (int c = 0; c < NCONN; c++)
    begin
      apb(1'b0, addr(c, KIND_STAT), 32'h0);
      chk_word(rd, 32'h00009401);
    end
    clk_run[0] <= 1'b0;
    repeat (300) @(posedge sys_clk_i);
    apb(1'b0, addr(0, KIND_STAT), 32'h0);
    chk_word(rd, 32'h00009201);
    chk_bit(irq_o, 1'b0);
    apb(1'b1, 32'h3c4, 32'h0000003f);
    repeat (3) @(posedge sys_clk_i);
    chk_bit(irq_o, 1'b1);
    apb(1'b0, 32'h3c0, 32'h0);
    chk_word(rd, 32'h00000002);
    apb(1'b1, 32'h3c0, 32'h00000002);
    repeat (3) @(posedge sys_clk_i);
    chk_bit(irq_o, 1'b0);
    clk_run[0] <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    apb(1'b0, addr(0, KIND_STAT), 32'h0);
    chk_word(rd, 32'h00009601);
    fault[1] <= 1'b1;
    wait_en(1'b0, 1, 1'b0, 50);
    repeat (300) @(posedge sys_clk_i);
    apb(1'b0, addr(1, KIND_STAT), 32'h0);
    chk_word(rd, 32'h000082c0);
    fault[1] <= 1'b0;
    repeat (600) @(posedge sys_clk_i);
    apb(1'b0, addr(1, KIND_STAT), 32'h0);
    chk_word(rd, 32'h00008280);
    apb(1'b0, 32'h3c0, 32'h0);
    chk_word(rd, 32'h0000000c);
    apb(1'b1, 32'h3c0, 32'h0000000c);
    apb(1'b1, addr(2, KIND_STAT), 32'h0000a000);
    fault[2] <= 1'b1;
    wait_en(1'b0, 2, 1'b0, 50);
    fault[2] <= 1'b0;
    wait_en(1'b0, 2, 1'b1, 2000);
    apb(1'b1, addr(0, KIND_STAT), 32'h0);
    wait_en(1'b0, 0, 1'b0, 10);
    plugged[0] <= 1'b0;
    plugged[1] <= 1'b0;
    apb(1'b1, addr(1, KIND_STAT), 32'h0);
    apb(1'b1, addr(0, KIND_STAT), 32'h00008000);
    apb(1'b1, addr(1, KIND_STAT), 32'h0000c000);
    wait_en(1'b0, 1, 1'b1, 1000);
    repeat (1000) @(posedge sys_clk_i);
    chk_bit(power_en_o[0], 1'b0);
    chk_bit(sense_en_o[0], 1'b1);
    plugged[2] <= 1'b0;
    wait_en(1'b0, 2, 1'b0, 500);
    apb(1'b0, addr(2, KIND_STAT), 32'h0);
    chk_word(rd & 32'h00001800, 32'h00001800);
    plugged[2] <= 1'b1;
    wait_en(1'b0, 2, 1'b1, 1000);
    hw_off[2] <= 1'b1;
    wait_en(1'b0, 2, 1'b0, 50);
    repeat (10) @(posedge sys_clk_i);
    hw_off[2] <= 1'b0;
    apb(1'b1, 32'h3c4, 32'h0);
    nrst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    apb(1'b0, addr(0, KIND_STAT), 32'h0);
    chk_word(rd, 32'h0);
    test_done();
  end
endmodule : clps_top_test
